// File: src/ast_pkg.sv
// Purpose: Shared constants and types of the asynchronous serial transceiver.
// Assumes: One 250 MHz core clock for both ends.
// Notes:   Register offsets are byte addresses of 32-bit words.
package ast_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  REG_DATA  = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam logic [7:0]  REG_CTRL  = 8'h08;
  localparam logic [7:0]  REG_BAUD  = 8'h0C;
  localparam logic [15:0] BAUD_RST  = 16'h0010;
  localparam logic [23:0] CTRL_RST  = 24'h00_0000;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int C_TXEN   = 0;
  localparam int C_RXEN   = 1;
  localparam int C_CTSEN  = 2;
  localparam int C_PAREN  = 3;
  localparam int C_PARODD = 4;
  localparam int C_STOP2  = 5;
  localparam int C_TXIE   = 6;
  localparam int C_RXIE   = 7;
  localparam int C_MULTIPROC_ENABLE   = 8;
  localparam int C_MPMD   = 9;
  localparam int C_MPTX   = 11;
  localparam int C_TMR    = 12;
  localparam int C_ADDR   = 16;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int S_RXAV   = 0;
  localparam int S_PARERR = 1;
  localparam int S_OVR    = 2;
  localparam int S_FRMERR = 3;
  localparam int S_BRK    = 4;
  localparam int S_TXHE   = 5;
  localparam int S_TXIDLE = 6;
  localparam int S_CTS    = 7;
  localparam int S_RXMARK = 8;
  localparam int S_TMR    = 9;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic {AST_TX_IDLE = 1'b0, AST_TX_SHIFT = 1'b1} ast_tx_e;
  typedef enum logic [1:0] {
    AST_RX_IDLE  = 2'b00,
    AST_RX_START = 2'b01,
    AST_RX_BITS  = 2'b11
  } ast_rx_e;

endpackage : ast_pkg

// File: src/ast_link_if.sv
// Purpose: Serial link between the transceiver and the remote node.
// Assumes: Both ends on core_clk; all lines are push-pull.
// Notes:   txd runs device to remote, rxd remote to device.
`timescale 1ns/100ps
interface ast_link_if;
  logic txd;
  logic rxd;
  logic ctsN;
  logic de;
  modport devEnd (output txd, output de, input rxd, input ctsN);
  modport farEnd (input txd, input de, output rxd, output ctsN);
endinterface : ast_link_if

// File: src/ast_remote.sv
// Purpose: Remote serial node facing the transceiver.
// Assumes: Same character format and bit period as the device.
// Notes:   Frames are sent and checked lsb first with one start bit.
`timescale 1ns/100ps
module ast_remote
  import ast_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  ast_link_if.farEnd       lnk,
  input  wire logic [15:0] bitCycles,
  input  wire logic        parityEn,
  input  wire logic        parityOdd,
  input  wire logic        twoStop,
  input  wire logic        multiproc_enable,
  input  wire logic        clearToSend,
  input  wire logic        sendValid,
  input  wire logic [7:0]  sendData,
  input  wire logic        sendMarker,
  output logic             sendReady,
  output logic             recvValid,
  output logic [7:0]       recvData,
  output logic             recvMarker,
  output logic             recvError
);

  typedef struct packed {
    ast_tx_e txSt; logic txd; logic ctsN; logic [11:0] sh;
    logic [3:0] txBits; logic [15:0] txCnt; logic rdy;
    ast_rx_e rxSt; logic s1; logic s2; logic [15:0] rxCnt;
    logic [3:0] rxBits; logic [9:0] rxSh; logic vld;
    logic [7:0] data; logic mark; logic err;
  } ast_rem_s;

  ast_rem_s st_r, st_nxt;
  logic [15:0] period;
  logic        ninthOn;
  logic [9:0]  v;

  assign period  = (bitCycles == 16'h0000) ? 16'h0001 : bitCycles;
  assign ninthOn = parityEn | multiproc_enable;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.vld  = 1'b0;
    st_nxt.ctsN = ~clearToSend;
    st_nxt.s1   = lnk.txd;
    st_nxt.s2   = st_r.s1;
    v           = ninthOn ? st_r.rxSh : {st_r.rxSh[9], 1'b0, st_r.rxSh[8:1]};
    unique case (st_r.txSt)
      AST_TX_IDLE:
      begin
        if (sendValid && st_r.rdy)
        begin
          st_nxt.sh     = ninthOn
                          ? {2'b11, (multiproc_enable ? sendMarker : (^sendData ^ parityOdd)), sendData, 1'b0}
                          : {3'b111, sendData, 1'b0};
          st_nxt.txBits = 4'(10 + ninthOn + twoStop);
          st_nxt.txCnt  = period - 16'h0001;
          st_nxt.txSt   = AST_TX_SHIFT;
          st_nxt.rdy    = 1'b0;
        end
      end
      AST_TX_SHIFT:
      begin
        if (st_r.txCnt == 16'h0000)
        begin
          st_nxt.txCnt = period - 16'h0001;
          st_nxt.sh    = {1'b1, st_r.sh[11:1]};
          st_nxt.txBits = st_r.txBits - 4'h1;
          if (st_r.txBits == 4'h1)
          begin
            st_nxt.txSt = AST_TX_IDLE;
            st_nxt.rdy  = 1'b1;
          end
        end
        else
        begin
          st_nxt.txCnt = st_r.txCnt - 16'h0001;
        end
      end
    endcase
    st_nxt.txd = (st_nxt.txSt == AST_TX_SHIFT) ? st_nxt.sh[0] : 1'b1;
    unique case (st_r.rxSt)
      AST_RX_IDLE:
      begin
        if (!st_r.s2)
        begin
          st_nxt.rxSt  = AST_RX_START;
          st_nxt.rxCnt = period >> 1;
        end
      end
      AST_RX_START:
      begin
        if (st_r.rxCnt != 16'h0000)
        begin
          st_nxt.rxCnt = st_r.rxCnt - 16'h0001;
        end
        else
        begin
          st_nxt.rxSt   = st_r.s2 ? AST_RX_IDLE : AST_RX_BITS;
          st_nxt.rxCnt  = period - 16'h0001;
          st_nxt.rxBits = 4'(9 + ninthOn);
        end
      end
      AST_RX_BITS:
      begin
        if (st_r.rxCnt != 16'h0000)
        begin
          st_nxt.rxCnt = st_r.rxCnt - 16'h0001;
        end
        else
        begin
          st_nxt.rxSh   = {st_r.s2, st_r.rxSh[9:1]};
          st_nxt.rxCnt  = period - 16'h0001;
          st_nxt.rxBits = st_r.rxBits - 4'h1;
          if (st_r.rxBits == 4'h1)
          begin
            st_nxt.rxSt = AST_RX_IDLE;
          end
        end
      end
      default: st_nxt.rxSt = AST_RX_IDLE;
    endcase
    if (st_r.rxSt == AST_RX_BITS && st_nxt.rxSt == AST_RX_IDLE)
    begin
      v          = ninthOn ? st_nxt.rxSh : {st_nxt.rxSh[9], 1'b0, st_nxt.rxSh[8:1]};
      st_nxt.vld  = 1'b1;
      st_nxt.data = v[7:0];
      st_nxt.mark = v[8];
      st_nxt.err  = ~v[9] | (parityEn & ~multiproc_enable & ((^v[7:0] ^ v[8]) != parityOdd));
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r       <= '0;
      st_r.txd   <= 1'b1;
      st_r.ctsN  <= 1'b1;
      st_r.rdy   <= 1'b1;
      st_r.s1    <= 1'b1;
      st_r.s2    <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign lnk.rxd    = st_r.txd;
  assign lnk.ctsN   = st_r.ctsN;
  assign sendReady  = st_r.rdy;
  assign recvValid  = st_r.vld;
  assign recvData   = st_r.data;
  assign recvMarker = st_r.mark;
  assign recvError  = st_r.err;

endmodule : ast_remote

// File: src/ast_device.sv
// Purpose: Asynchronous serial transceiver with an APB register slave.
// Assumes: APB master on core_clk; link lines come from pins.
// Notes:   Every APB access takes one wait cycle; pready is registered.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps

module ast_device
  import ast_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irqTx,
  output logic                   irqRx,
  ast_link_if.devEnd             lnk
);

  typedef struct packed {
    ast_tx_e txSt; logic txd; logic de; logic [7:0] hold; logic holdFull;
    logic holdMark; logic [11:0] sh; logic [3:0] txBits; logic [15:0] baud_divider;
    ast_rx_e rxSt; logic rxS1; logic rxS2; logic ctsS1; logic ctsS2;
    logic [15:0] rxCnt; logic [3:0] rxBits; logic [9:0] rxSh;
    logic [7:0] rxData; logic rxMark; logic rxAvail; logic parErr;
    logic ovr; logic frmErr; logic brk; logic inFrame; logic tmrDone;
    logic [23:0] ctrl; logic [15:0] baud; logic pready; logic pslverr;
    logic [31:0] prdata; logic irqTx; logic irqRx;
  } ast_dev_s;

  ast_dev_s    st_r, st_nxt;
  logic [15:0] period;
  logic        brgTick;
  logic        ninthOn;
  logic        done;
  logic        accept;
  logic        hit;
  logic [9:0]  v;
  logic [31:0] statWord;

  // ----------------------------------------
  // Shared rate and format
  // ----------------------------------------
  // One rate, one format.
  assign period  = (st_r.baud == 16'h0000) ? 16'h0001 : st_r.baud;
  assign brgTick = (st_r.baud_divider == 16'h0000);
  assign ninthOn = st_r.ctrl[C_PAREN] | st_r.ctrl[C_MULTIPROC_ENABLE];
  assign done    = psel & penable & st_r.pready;
  assign hit     = (paddr == REG_DATA) | (paddr == REG_STAT) |
                   (paddr == REG_CTRL) | (paddr == REG_BAUD);

  always_comb
  begin
    statWord           = 32'h0000_0000;
    statWord[S_RXAV]   = st_r.rxAvail;
    statWord[S_PARERR] = st_r.parErr;
    statWord[S_OVR]    = st_r.ovr;
    statWord[S_FRMERR] = st_r.frmErr;
    statWord[S_BRK]    = st_r.brk;
    statWord[S_TXHE]   = ~st_r.holdFull;
    statWord[S_TXIDLE] = (st_r.txSt == AST_TX_IDLE);
    statWord[S_CTS]    = ~st_r.ctsS2;
    statWord[S_RXMARK] = st_r.rxMark;
    statWord[S_TMR]    = st_r.tmrDone;
  end

  always_comb
  begin
    st_nxt       = st_r;
    accept       = 1'b0;
    v            = 10'h000;
    st_nxt.rxS1  = lnk.rxd;
    st_nxt.rxS2  = st_r.rxS1;
    st_nxt.ctsS1 = lnk.ctsN;
    st_nxt.ctsS2 = st_r.ctsS1;

    // ----------------------------------------
    // Baud divider and timer
    // ----------------------------------------
    // Divider reload, timer flag.
    st_nxt.baud_divider = brgTick ? (period - 16'h0001) : (st_r.baud_divider - 16'h0001);
    if (brgTick && st_r.ctrl[C_TMR])
    begin
      st_nxt.tmrDone = 1'b1;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    unique case (st_r.txSt)
      AST_TX_IDLE:
      begin
        if (brgTick && st_r.holdFull && st_r.ctrl[C_TXEN] &&
            (!st_r.ctrl[C_CTSEN] || !st_r.ctsS2))
        begin
          st_nxt.holdFull = 1'b0;
          st_nxt.sh = ninthOn
                      ? {2'b11, (st_r.ctrl[C_MULTIPROC_ENABLE] ? st_r.holdMark
                                 : (^st_r.hold ^ st_r.ctrl[C_PARODD])), st_r.hold, 1'b0}
                      : {3'b111, st_r.hold, 1'b0};
          st_nxt.txBits = 4'(10 + ninthOn + st_r.ctrl[C_STOP2]);
          st_nxt.txSt   = AST_TX_SHIFT;
        end
      end
      AST_TX_SHIFT:
      begin
        // Runs to the end regardless of flow gate.
        if (brgTick)
        begin
          st_nxt.sh     = {1'b1, st_r.sh[11:1]};
          st_nxt.txBits = st_r.txBits - 4'h1;
          if (st_r.txBits == 4'h1)
          begin
            st_nxt.txSt = AST_TX_IDLE;
          end
        end
      end
    endcase
    st_nxt.txd = (st_nxt.txSt == AST_TX_SHIFT) ? st_nxt.sh[0] : 1'b1;
    st_nxt.de  = (st_nxt.txSt == AST_TX_SHIFT);

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    unique case (st_r.rxSt)
      AST_RX_IDLE:
      begin
        if (st_r.ctrl[C_RXEN] && !st_r.rxS2)
        begin
          st_nxt.rxSt  = AST_RX_START;
          st_nxt.rxCnt = period >> 1;
        end
      end
      AST_RX_START:
      begin
        if (st_r.rxCnt != 16'h0000)
        begin
          st_nxt.rxCnt = st_r.rxCnt - 16'h0001;
        end
        else
        begin
          // A start edge that is high again at mid-bit was a glitch.
          st_nxt.rxSt   = st_r.rxS2 ? AST_RX_IDLE : AST_RX_BITS;
          st_nxt.rxCnt  = period - 16'h0001;
          st_nxt.rxBits = 4'(9 + ninthOn);
        end
      end
      AST_RX_BITS:
      begin
        if (st_r.rxCnt != 16'h0000)
        begin
          st_nxt.rxCnt = st_r.rxCnt - 16'h0001;
        end
        else
        begin
          st_nxt.rxSh   = {st_r.rxS2, st_r.rxSh[9:1]};
          st_nxt.rxCnt  = period - 16'h0001;
          st_nxt.rxBits = st_r.rxBits - 4'h1;
          if (st_r.rxBits == 4'h1)
          begin
            st_nxt.rxSt = AST_RX_IDLE;
            v = ninthOn ? st_nxt.rxSh : {st_nxt.rxSh[9], 1'b0, st_nxt.rxSh[8:1]};
            if (!st_r.ctrl[C_MULTIPROC_ENABLE])
            begin
              accept = 1'b1;
            end
            else
            begin
              unique case (st_r.ctrl[C_MPMD +: 2])
                2'b00: accept = 1'b1;
                2'b01: accept = v[8];
                2'b10:
                begin
                  if (v[8])
                  begin
                    st_nxt.inFrame = (v[7:0] == st_r.ctrl[C_ADDR +: 8]);
                  end
                  accept = v[8] ? st_nxt.inFrame : st_r.inFrame;
                end
                2'b11: accept = ~v[8];
              endcase
            end
          end
        end
      end
      default: st_nxt.rxSt = AST_RX_IDLE;
    endcase

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    st_nxt.pready  = psel & penable & ~st_r.pready;
    st_nxt.pslverr = psel & penable & ~st_r.pready & ~hit;
    st_nxt.prdata  = 32'h0000_0000;
    if (psel && penable && !st_r.pready && !pwrite)
    begin
      unique case (paddr)
        REG_DATA: st_nxt.prdata = {24'h00_0000, st_r.rxData};
        REG_STAT: st_nxt.prdata = statWord;
        REG_CTRL: st_nxt.prdata = {8'h00, st_r.ctrl};
        REG_BAUD: st_nxt.prdata = {16'h0000, st_r.baud};
        default:  st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (done && pwrite)
    begin
      unique case (paddr)
        REG_DATA:
        begin
          // A write while the holding register is full is dropped.
          if (!st_r.holdFull)
          begin
            st_nxt.hold     = pwdata[7:0];
            st_nxt.holdMark = st_r.ctrl[C_MPTX];
            st_nxt.holdFull = 1'b1;
          end
        end
        REG_STAT:
        begin
          st_nxt.parErr  = st_r.parErr & ~pwdata[S_PARERR];
          st_nxt.ovr     = st_r.ovr & ~pwdata[S_OVR];
          st_nxt.frmErr  = st_r.frmErr & ~pwdata[S_FRMERR];
          st_nxt.brk     = st_r.brk & ~pwdata[S_BRK];
          st_nxt.tmrDone = st_nxt.tmrDone & ~(pwdata[S_TMR] & ~(brgTick & st_r.ctrl[C_TMR]));
        end
        REG_CTRL: st_nxt.ctrl = pwdata[23:0];
        REG_BAUD: st_nxt.baud = pwdata[15:0];
        default: ;
      endcase
    end
    if (done && !pwrite && paddr == REG_DATA)
    begin
      st_nxt.rxAvail = 1'b0;
    end

    // Captured after the clears so that a new event wins over them.
    if (accept)
    begin
      st_nxt.ovr     = st_nxt.ovr | st_r.rxAvail;
      st_nxt.frmErr  = st_nxt.frmErr | ~v[9];
      st_nxt.brk     = st_nxt.brk | ((v[8:0] == 9'h000) & ~v[9]);
      st_nxt.parErr  = st_nxt.parErr | (st_r.ctrl[C_PAREN] & ~st_r.ctrl[C_MULTIPROC_ENABLE] &
                       ((^v[7:0] ^ v[8]) != st_r.ctrl[C_PARODD]));
      st_nxt.rxData  = v[7:0];
      st_nxt.rxMark  = v[8];
      st_nxt.rxAvail = 1'b1;
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    // Level requests.
    st_nxt.irqTx = st_nxt.ctrl[C_TXEN] & st_nxt.ctrl[C_TXIE] & ~st_nxt.holdFull;
    st_nxt.irqRx = st_nxt.ctrl[C_RXIE] & (st_nxt.rxAvail | st_nxt.parErr |
                   st_nxt.ovr | st_nxt.frmErr | st_nxt.brk);
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r       <= '0;
      st_r.txd   <= 1'b1;
      st_r.rxS1  <= 1'b1;
      st_r.rxS2  <= 1'b1;
      st_r.ctsS1 <= 1'b1;
      st_r.ctsS2 <= 1'b1;
      st_r.ctrl  <= CTRL_RST;
      st_r.baud  <= BAUD_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irqTx   = st_r.irqTx;
  assign irqRx   = st_r.irqRx;
  assign lnk.txd = st_r.txd;
  assign lnk.de  = st_r.de;

endmodule : ast_device

// File: dv/ast_link_asserts.sv
// Purpose: Checker for the serial link between the two ends.
// Assumes: Bit period stays at BIT core cycles for the whole run.
// Notes:   Sees only the link lines, clock and reset.
`timescale 1ns/100ps
module ast_link_asserts #(
  parameter int BIT = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic txd,
  input wire logic rxd,
  input wire logic ctsN,
  input wire logic de
);
  // ----
  // Run counters
  // ----
  // de drops for a bit between characters and their length varies with format, so only whole multiples of a bit are checked.
  logic [15:0] deCnt_r;
  logic [15:0] txLow_r;
  logic [15:0] rxLow_r;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      deCnt_r <= 16'h0000;
      txLow_r <= 16'h0000;
      rxLow_r <= 16'h0000;
    end
    else
    begin
      deCnt_r <= de ? deCnt_r + 16'h0001 : 16'h0000;
      txLow_r <= txd ? 16'h0000 : txLow_r + 16'h0001;
      rxLow_r <= rxd ? 16'h0000 : rxLow_r + 16'h0001;
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_idle_line_high: assert property (!de |-> txd)
    else $error("transmit line low outside a character");
  a_start_bit_low: assert property ($rose(de) |-> (!txd) [*8])
    else $error("character did not open with a low start bit");
  a_bit_edge_aligned: assert property ((de && $changed(txd)) |-> deCnt_r % BIT == 0)
    else $error("transmit line moved inside a bit period");
  a_whole_char_sent: assert property ($fell(de) |-> deCnt_r % BIT == 0 && deCnt_r >= 10 * BIT)
    else $error("driver enable dropped inside a character");
  a_stop_bit_high: assert property ($fell(de) |-> $past(txd))
    else $error("last bit of a character was not high");
  a_remote_start_low: assert property ($fell(rxd) |-> (!rxd) [*8])
    else $error("remote character start bit too short");
  a_tx_low_bound: assert property (txLow_r <= 10 * BIT)
    else $error("transmit line low longer than one character");
  a_rx_low_bound: assert property (rxLow_r <= 10 * BIT)
    else $error("receive line low longer than one character");
endmodule : ast_link_asserts

// File: dv/testbench.sv
// Purpose: Self-checking bench for the transceiver facing the remote node.
// Assumes: Bit period stays at its reset value of 16 core cycles.
// Notes:   Reads and received characters are checked in order from queues.
`timescale 1ns/100ps
module testbench
  import ast_pkg::*;
;
  localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
  logic        core_clk    = 1'b0;
  logic        reset       = 1'b1;
  logic [7:0]  paddr       = 8'h00;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [3:0]  fmt         = 4'h0;
  logic        clearToSend = 1'b0;
  logic        sendValid   = 1'b0;
  logic        sendMarker  = 1'b0;
  logic [7:0]  sendData    = 8'h00;
  logic [31:0] prdata, rdv, ctl;
  logic        pready, pslverr, irqTx, irqRx, sendReady, recvValid, recvMarker, recvError;
  logic [7:0]  recvData, d;
  logic [19:0] charQ[$];
  logic [65:0] rdQ[$];
  int          mismatches = 0;
  int          n_checks   = 0;
  int          seed       = 86;
  logic [3:0]  fmts[5]    = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hC};

  ast_link_if lnk();
  ast_device ast_device_inst (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqTx(irqTx), .irqRx(irqRx), .lnk(lnk));
  ast_remote ast_remote_inst (.core_clk(core_clk), .reset(reset), .lnk(lnk),
    .bitCycles(16'h0010), .parityEn(fmt[0]), .parityOdd(fmt[1]), .twoStop(fmt[2]),
    .multiproc_enable(fmt[3]), .clearToSend(clearToSend), .sendValid(sendValid), .sendData(sendData),
    .sendMarker(sendMarker), .sendReady(sendReady), .recvValid(recvValid),
    .recvData(recvData), .recvMarker(recvMarker), .recvError(recvError));
  ast_link_asserts #(.BIT(16)) chk (.core_clk(core_clk), .reset(reset), .txd(lnk.txd),
    .rxd(lnk.rxd), .ctsN(lnk.ctsN), .de(lnk.de));

  always #2 core_clk = ~core_clk;

  // ----
  // Checking
  // ----
  task wrap_up;
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task hang;
    mismatches++;
    wrap_up();
  endtask : hang

  task note(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : note

  task cmp_word(input logic [32:0] got, input logic [65:0] em);
    note(got & em[65:33], em[32:0] & em[65:33]);
  endtask : cmp_word

  task cmp_char(input logic [9:0] got, input logic [19:0] em);
    note({23'h0, got & em[19:10]}, {23'h0, em[9:0] & em[19:10]});
  endtask : cmp_char

  task cmp_bit(input logic got, input logic exp);
    note({32'h0, got}, {32'h0, exp});
  endtask : cmp_bit

  always @(posedge core_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_word({pslverr, prdata}, rdQ.size() ? rdQ.pop_front() : {ALL, ALL});
    if (recvValid === 1'b1)
      cmp_char({recvError, recvMarker, recvData}, charQ.size() ? charQ.pop_front() : 20'hF_FFFF);
  end

  // ----
  // Drivers
  // ----
  task apb(input logic [7:0] a, input logic w, input logic [31:0] dw, input logic [65:0] em);
    int k;
    @(posedge core_clk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= dw;
    psel   <= 1'b1;
    if (!w)
      rdQ.push_back(em);
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
      hang();
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] dw);
    apb(a, 1'b1, dw, 66'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(a, 1'b0, 32'h0000_0000, {m, e});
  endtask : rd

  task setf(input logic [3:0] f, input logic [31:0] en);
    fmt <= f;
    ctl = en | (32'(f[0]) << C_PAREN) | (32'(f[1]) << C_PARODD);
    ctl = ctl | (32'(f[2]) << C_STOP2) | (32'(f[3]) << C_MULTIPROC_ENABLE);
    wr(REG_CTRL, ctl);
  endtask : setf

  task tx(input logic mk);
    int k;
    d = 8'($random(seed));
    wr(REG_CTRL, ctl | (32'(mk) << C_MPTX));
    for (k = 0; k < 400; k++)
    begin
      rd(REG_STAT, 33'h0, 33'h0);
      if (rdv[S_TXHE] === 1'b1)
        break;
    end
    if (k == 400)
      hang();
    wr(REG_DATA, {24'h00_0000, d});
    charQ.push_back({1'b1, fmt[3], 8'hFF, 1'b0, mk, d});
  endtask : tx

  task rsend(input logic [7:0] dr, input logic mk);
    int k;
    @(posedge core_clk);
    sendValid  <= 1'b1;
    sendData   <= dr;
    sendMarker <= mk;
    @(posedge core_clk);
    sendValid <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (k = 0; k < 400 && sendReady !== 1'b1; k++)
      @(posedge core_clk);
    if (k == 400)
      hang();
  endtask : rsend

  task waitq(input int n);
    int k;
    for (k = 0; k < 3000 && charQ.size() > n; k++)
      @(posedge core_clk);
    if (k == 3000)
      hang();
  endtask : waitq

  // ----
  // Scenarios
  // ----
  initial
  begin
    int k;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rd(REG_CTRL, 33'h0, ALL);
    rd(REG_BAUD, 33'h0_0000_0010, ALL);
    rd(REG_STAT, 33'h0_0000_0060, ALL);
    rd(8'h10, 33'h1_0000_0000, ALL);
    cmp_bit(irqTx, 1'b0);
    setf(4'h0, 32'h0000_0041);
    repeat (2) @(posedge core_clk);
    cmp_bit(irqTx, 1'b1);
    // parity is never enabled together with multiprocessor mode.
    foreach (fmts[i])
    begin
      setf(fmts[i], 32'h0000_0001);
      tx(1'b1);
      tx(1'b0);
      cmp_bit(charQ.size() == 2, 1'b1);
      waitq(0);
    end
    setf(4'h0, 32'h0000_0005);
    tx(1'b0);
    repeat (100) @(posedge core_clk);
    cmp_bit(lnk.de, 1'b0);
    rd(REG_STAT, 33'h0, 33'h0_0000_0020);
    clearToSend <= 1'b1;
    for (k = 0; k < 200 && lnk.de !== 1'b1; k++)
      @(posedge core_clk);
    if (k == 200)
      hang();
    clearToSend <= 1'b0;
    tx(1'b0);
    waitq(1);
    repeat (60) @(posedge core_clk);
    cmp_bit(lnk.de, 1'b0);
    clearToSend <= 1'b1;
    waitq(0);
    setf(4'h1, 32'h0000_0000);
    rsend(8'($random(seed)), 1'b0);
    rd(REG_STAT, 33'h0, 33'h0_0000_0001);
    setf(4'h1, 32'h0000_0082);
    d = 8'($random(seed));
    rsend(d, 1'b0);
    cmp_bit(irqRx, 1'b1);
    cmp_bit(irqTx, 1'b0);
    rd(REG_DATA, {25'h0, d}, 33'h0_0000_00FF);
    fmt <= 4'h3;
    rsend(d, 1'b0);
    rd(REG_STAT, 33'h0_0000_0003, 33'h0_0000_0003);
    fmt <= 4'h1;
    d = 8'($random(seed));
    rsend(d, 1'b0);
    rd(REG_STAT, 33'h0_0000_0004, 33'h0_0000_0004);
    rd(REG_DATA, {25'h0, d}, 33'h0_0000_00FF);
    wr(REG_STAT, 32'h0000_001E);
    rd(REG_STAT, 33'h0, 33'h0_0000_001F);
    setf(4'h0, 32'h0000_1000);
    repeat (40) @(posedge core_clk);
    rd(REG_STAT, 33'h0_0000_0200, 33'h0_0000_0200);
    setf(4'h8, 32'h0000_0202);
    rsend(d, 1'b0);
    rd(REG_STAT, 33'h0, 33'h0_0000_0001);
    rsend(d, 1'b1);
    rd(REG_STAT, 33'h0_0000_0101, 33'h0_0000_0101);
    rd(REG_DATA, {25'h0, d}, 33'h0_0000_00FF);
    setf(4'h8, 32'h0000_0602);
    rsend(d, 1'b1);
    rd(REG_STAT, 33'h0, 33'h0_0000_0001);
    rsend(d, 1'b0);
    rd(REG_STAT, 33'h0_0000_0001, 33'h0_0000_0101);
    wrap_up();
  end
endmodule : testbench
